// *** rgbi_defs.svh ***
/*
 * Constants of the parallel RGB pixel input: widths, frame geometry, FIFO depth.
 * Assumes it is included by the package and the design file by its bare name.
 */
// What this block does
// - In RGB mode all scan timing runs on the external pixel clock.
// - After a frame, stay in front porch until next vertical sync.
// - Vertical sync falling edge loads frame start address into counter.
// - Vertical sync is active low on both sides.
// - Horizontal sync is active low on both sides.
// - Pixels are written only while pixel_valid is high.
// - No partial display, scrolling, interlace or graphics in RGB mode.
// - Low hard reset resets the whole block while held.
// - During hard reset the serial select input is ignored.
// - Any serial select level, even tied low, leaves operation correct.
// - A pixel is 18 bits: red, green, blue fields of 6 bits.
// - After uncontrolled power loss the display blanks until a reset with power good.
`ifndef RGBI_DEFS_SVH
`define RGBI_DEFS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define RGBI_COLOR_W 6
`define RGBI_ADDR_W 17
`define RGBI_FRAME_START 17'h0_0000
`define RGBI_FRAME_LAST 17'h1_5DFF
`define RGBI_ADDR_STEP 17'h0_0001

// ----------------------------------------
// Buffering and identity
// ----------------------------------------
`define RGBI_FIFO_DEPTH 8
`define RGBI_FIFO_AW 3
// Arbitrary tag levels
`define RGBI_TAG_BIT0 1'h0
`define RGBI_TAG_BIT1 1'h0

`endif

// *** rgbi_pkg.sv ***
/*
 * Types of the parallel RGB pixel input.
 * Assumes rgbi_defs.svh is on the include path.
 */
`include "rgbi_defs.svh"

package rgbi_pkg;

   // ----------------------------------------
   // Pixel and memory word
   // ----------------------------------------
   typedef struct packed {
      logic [`RGBI_COLOR_W-1:0] red;
      logic [`RGBI_COLOR_W-1:0] green;
      logic [`RGBI_COLOR_W-1:0] blue;
   } rgbi_pixel_s;

   typedef struct packed {
      logic [`RGBI_ADDR_W-1:0] addr;
      rgbi_pixel_s pixel;
   } rgbi_word_s;

   typedef enum logic {
      rgbi_front_porch,
      rgbi_active
   } rgbi_scan_e;

endpackage : rgbi_pkg

// *** rgbi_top.sv ***
/*
 * Parallel RGB pixel input: capture on the pixel clock, address counting,
 * dual-clock FIFO into the system clock, memory write port and blanking.
 * Assumes a memory that accepts words with valid/ready on the system clock.
 */
`timescale 1ns/1ps
`include "rgbi_defs.svh"

// ----------------------------------------
// Dual-clock FIFO with gray pointers
// ----------------------------------------
module rgbi_fifo #(
   parameter int WIDTH = 35,
   parameter int DEPTH = `RGBI_FIFO_DEPTH,
   parameter int AW = `RGBI_FIFO_AW
) (
   // Fill side
   input wire logic i_wr_clk,
   input wire logic i_wr_rst,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   // Drain side
   input wire logic i_rd_clk,
   input wire logic i_rd_rst,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] far1;
      logic [AW:0] far2;
   } rgbi_ptr_s;

   logic [WIDTH-1:0] mem [DEPTH];
   rgbi_ptr_s w_q, w_d, r_q, r_d;
   logic push, pop;

   assign o_wr_ready = (w_q.gray != {~w_q.far2[AW:AW-1], w_q.far2[AW-2:0]});
   assign o_rd_valid = (r_q.gray != r_q.far2);
   assign o_rd_data = mem[r_q.bin[AW-1:0]];
   assign push = i_wr_valid & o_wr_ready;
   assign pop = o_rd_valid & i_rd_ready;

   always_comb begin
      w_d = w_q;
      w_d.far1 = r_q.gray;
      w_d.far2 = w_q.far1;
      if (push) begin
         w_d.bin = w_q.bin + 1'b1;
         w_d.gray = w_d.bin ^ (w_d.bin >> 1);
      end
      if (i_wr_rst) begin
         w_d.bin = '0;
         w_d.gray = '0;
      end
   end

   always_comb begin
      r_d = r_q;
      r_d.far1 = w_q.gray;
      r_d.far2 = r_q.far1;
      if (pop) begin
         r_d.bin = r_q.bin + 1'b1;
         r_d.gray = r_d.bin ^ (r_d.bin >> 1);
      end
      if (i_rd_rst) begin
         r_d.bin = '0;
         r_d.gray = '0;
      end
   end

   always_ff @(posedge i_wr_clk) begin
      w_q <= w_d;
      if (push) begin
         mem[w_q.bin[AW-1:0]] <= i_wr_data;
      end
   end

   always_ff @(posedge i_rd_clk) begin
      r_q <= r_d;
   end
endmodule : rgbi_fifo

// ----------------------------------------
// Top
// ----------------------------------------
module rgbi_top (
   // System clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Module pins
   input wire logic i_hard_reset_n,
   input wire logic i_serial_select_n,
   input wire logic i_rgb_mode,
   input wire logic i_power_good,
   // Pixel link
   input wire logic i_pixel_clock_in,
   input wire logic i_vsync_n,
   input wire logic i_hsync_n,
   input wire logic i_pixel_valid,
   input wire logic [`RGBI_COLOR_W-1:0] i_red_bus,
   input wire logic [`RGBI_COLOR_W-1:0] i_green_bus,
   input wire logic [`RGBI_COLOR_W-1:0] i_blue_bus,
   // Display memory write port
   output logic o_mem_wr_valid,
   input wire logic i_mem_wr_ready,
   output logic [`RGBI_ADDR_W-1:0] o_mem_wr_addr,
   output rgbi_pkg::rgbi_pixel_s o_mem_wr_pixel,
   // Status
   output logic o_frame_start,
   output logic o_display_blank,
   output logic o_serial_select_active,
   output logic o_panel_tag_bit0,
   output logic o_panel_tag_bit1
);
   typedef struct packed {
      rgbi_pkg::rgbi_pixel_s cap_pix;
      logic cap_valid;
      logic cap_vs_n;
      logic cap_hs_n;
      rgbi_pkg::rgbi_pixel_s stg_pix;
      logic stg_valid;
      logic stg_vs_n;
      logic stg_hs_n;
      logic rst1;
      logic rst2;
      logic mode1;
      logic mode2;
      logic vs_prev;
      rgbi_pkg::rgbi_scan_e scan;
      logic [`RGBI_ADDR_W-1:0] addr;
      logic frame_tog;
   } rgbi_link_s;

   typedef struct packed {
      logic hrst1;
      logic hrst2;
      logic pg1;
      logic pg2;
      logic cs1;
      logic cs2;
      logic tog1;
      logic tog2;
      logic tog3;
      logic rst;
      logic lrst1;
      logic lrst2;
      logic blank;
      logic frame_start;
      logic select_active;
      logic out_valid;
      rgbi_pkg::rgbi_word_s out_word;
      logic tag0;
      logic tag1;
   } rgbi_sys_s;

   rgbi_link_s l_q, l_d;
   rgbi_sys_s s_q, s_d;
   rgbi_pkg::rgbi_word_s wr_word, rd_word;
   logic wr_valid, wr_ready, rd_valid, rd_ready, vs_fall, sys_rst, link_rst;

   // ----------------------------------------
   // Pixel clock domain
   // ----------------------------------------
   // Low line sync drops
   assign wr_valid = (l_q.scan == rgbi_pkg::rgbi_active) & l_q.stg_valid & l_q.stg_hs_n & l_q.mode2 & ~l_q.rst2;
   assign wr_word = '{addr: l_q.addr, pixel: l_q.stg_pix};
   assign vs_fall = l_q.vs_prev & ~l_q.stg_vs_n;

   always_comb begin
      l_d = l_q;
      l_d.cap_pix = '{red: i_red_bus, green: i_green_bus, blue: i_blue_bus};
      l_d.cap_valid = i_pixel_valid;
      l_d.cap_vs_n = i_vsync_n;
      l_d.cap_hs_n = i_hsync_n;
      l_d.stg_pix = l_q.cap_pix;
      l_d.stg_valid = l_q.cap_valid;
      l_d.stg_vs_n = l_q.cap_vs_n;
      l_d.stg_hs_n = l_q.cap_hs_n;
      l_d.rst1 = s_q.rst;
      l_d.rst2 = l_q.rst1;
      l_d.mode1 = i_rgb_mode;
      l_d.mode2 = l_q.mode1;
      l_d.vs_prev = l_q.stg_vs_n;
      if (vs_fall & l_q.mode2) begin
         l_d.addr = `RGBI_FRAME_START;
         l_d.scan = rgbi_pkg::rgbi_active;
         l_d.frame_tog = ~l_q.frame_tog;
      end else if (wr_valid & wr_ready) begin
         // Strictly linear fill, no window or scroll
         l_d.addr = l_q.addr + `RGBI_ADDR_STEP;
         if (l_q.addr == `RGBI_FRAME_LAST) begin
            l_d.scan = rgbi_pkg::rgbi_front_porch;
         end
      end
      if (l_q.rst2) begin
         l_d.scan = rgbi_pkg::rgbi_front_porch;
         l_d.addr = `RGBI_FRAME_START;
         l_d.vs_prev = 1'b0;
         l_d.frame_tog = 1'b0;
      end
   end

   always_ff @(posedge i_pixel_clock_in) begin
      l_q <= l_d;
   end

   // ----------------------------------------
   // Crossing buffer
   // ----------------------------------------
   // Full FIFO stalls the address counter, so a dropped pixel's address goes to the next accepted pixel
   rgbi_fifo #(
      .WIDTH($bits(rgbi_pkg::rgbi_word_s)),
      .DEPTH(`RGBI_FIFO_DEPTH),
      .AW(`RGBI_FIFO_AW)
   ) u_fifo (
      .i_wr_clk(i_pixel_clock_in),
      .i_wr_rst(l_q.rst2),
      .i_wr_valid(wr_valid),
      .o_wr_ready(wr_ready),
      .i_wr_data(wr_word),
      .i_rd_clk(i_clk),
      .i_rd_rst(link_rst),
      .o_rd_valid(rd_valid),
      .i_rd_ready(rd_ready),
      .o_rd_data(rd_word)
   );

   // ----------------------------------------
   // System clock domain
   // ----------------------------------------
   // Low hard reset holds everything
   assign sys_rst = i_srst | ~s_q.hrst2;
   // Read side stays in reset until the link side has been seen in reset,
   // so a short reset can never leave one FIFO pointer ahead of the other
   assign link_rst = s_q.rst | s_q.lrst2;
   assign rd_ready = (~s_q.out_valid | i_mem_wr_ready) & ~link_rst;

   always_comb begin
      s_d = s_q;
      s_d.hrst1 = i_hard_reset_n;
      s_d.hrst2 = s_q.hrst1;
      s_d.pg1 = i_power_good;
      s_d.pg2 = s_q.pg1;
      s_d.cs1 = i_serial_select_n;
      s_d.cs2 = s_q.cs1;
      s_d.tog1 = l_q.frame_tog;
      s_d.tog2 = s_q.tog1;
      s_d.tog3 = s_q.tog2;
      s_d.lrst1 = l_q.rst2;
      s_d.lrst2 = s_q.lrst1;
      // Link reset holds until its echo returns
      s_d.rst = sys_rst | (s_q.rst & ~s_q.lrst2);
      s_d.tag0 = `RGBI_TAG_BIT0;
      s_d.tag1 = `RGBI_TAG_BIT1;
      s_d.frame_start = s_q.tog2 ^ s_q.tog3;
      // Select level never touches the pixel path
      s_d.select_active = ~s_q.cs2;
      if (rd_valid & rd_ready) begin
         s_d.out_valid = 1'b1;
         s_d.out_word = rd_word;
      end else if (i_mem_wr_ready) begin
         s_d.out_valid = 1'b0;
      end
      if (~s_q.pg2) begin
         s_d.blank = 1'b1;
      end
      if (link_rst) begin
         s_d.tog1 = 1'b0;
         s_d.tog2 = 1'b0;
         s_d.tog3 = 1'b0;
         s_d.frame_start = 1'b0;
      end
      if (sys_rst) begin
         s_d.select_active = 1'b0;
         s_d.out_valid = 1'b0;
         s_d.frame_start = 1'b0;
         // Only a reset with good power ends the blank
         s_d.blank = ~s_q.pg2;
      end
   end

   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end

   assign o_mem_wr_valid = s_q.out_valid;
   assign o_mem_wr_addr = s_q.out_word.addr;
   assign o_mem_wr_pixel = s_q.out_word.pixel;
   assign o_frame_start = s_q.frame_start;
   assign o_display_blank = s_q.blank;
   assign o_serial_select_active = s_q.select_active;
   assign o_panel_tag_bit0 = s_q.tag0;
   assign o_panel_tag_bit1 = s_q.tag1;
endmodule : rgbi_top

// *** rgbi_monitor.sv ***
/* Port checker for rgbi_top.
 * Bound into rgbi_top; every check runs on i_clk. */
`timescale 1ns/1ps
`include "rgbi_defs.svh"
module rgbi_top_chk (
   // System
   input wire logic i_clk,
   input wire logic i_srst,
   // Pins
   input wire logic i_hard_reset_n,
   input wire logic i_serial_select_n,
   input wire logic i_power_good,
   // Memory port
   input wire logic o_mem_wr_valid,
   input wire logic i_mem_wr_ready,
   input wire logic [`RGBI_ADDR_W-1:0] o_mem_wr_addr,
   // Status
   input wire logic o_frame_start,
   input wire logic o_display_blank,
   input wire logic o_serial_select_active
);
   // ------
   // Helpers
   // ------
   logic first_q, have_q;
   logic [5:0] hr_q;
   logic [`RGBI_ADDR_W-1:0] last_q;
   always_ff @(posedge i_clk) begin
      hr_q <= {hr_q[4:0], i_hard_reset_n};
      if (i_srst || o_frame_start) begin
         first_q <= o_frame_start;
         have_q <= 1'b0;
      end else if (o_mem_wr_valid && i_mem_wr_ready) begin
         first_q <= 1'b0;
         have_q <= 1'b1;
         last_q <= o_mem_wr_addr;
      end
   end
   // ------
   // Properties
   // ------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // Hard reset held past its two-stage sync
   sequence s_hard_held;
      !i_hard_reset_n [*6];
   endsequence
   sequence s_sel_steady;
      (i_hard_reset_n && $stable(i_serial_select_n)) [*6];
   endsequence
   property p_sel_ignored;
      s_hard_held |-> !o_serial_select_active;
   endproperty
   a_sel_ignored: assert property (p_sel_ignored) else $error("select seen in reset");
   property p_reset_quiet;
      s_hard_held |-> !o_mem_wr_valid && !o_frame_start;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("activity in reset");
   property p_sel_follows;
      s_sel_steady |-> o_serial_select_active == !i_serial_select_n;
   endproperty
   a_sel_follows: assert property (p_sel_follows) else $error("select not followed");
   property p_blank_on_loss;
      !i_power_good [*4] |-> o_display_blank;
   endproperty
   a_blank_on_loss: assert property (p_blank_on_loss) else $error("not blank");
   // Only a reset may lift the blanking
   property p_blank_holds;
      $fell(o_display_blank) |-> $past(i_srst) || !(&hr_q);
   endproperty
   a_blank_holds: assert property (p_blank_holds) else $error("blank lifted");
   property p_start_pulse;
      o_frame_start |=> !o_frame_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("long frame start");
   property p_first_addr;
      o_mem_wr_valid && first_q |-> o_mem_wr_addr == `RGBI_FRAME_START;
   endproperty
   a_first_addr: assert property (p_first_addr) else $error("bad first address");
   property p_ascend;
      o_mem_wr_valid && have_q && !first_q |-> o_mem_wr_addr == last_q + `RGBI_ADDR_STEP;
   endproperty
   a_ascend: assert property (p_ascend) else $error("address skipped");
endmodule : rgbi_top_chk
bind rgbi_top rgbi_top_chk u_chk (.i_clk, .i_srst, .i_hard_reset_n, .i_serial_select_n,
   .i_power_good, .o_mem_wr_valid, .i_mem_wr_ready, .o_mem_wr_addr, .o_frame_start,
   .o_display_blank, .o_serial_select_active);

// *** rgbi_host.sv ***
/* Host controller model on the pixel link.
 * Assumes one bench process calls its tasks in turn. */
`timescale 1ns/1ps
`include "rgbi_defs.svh"
module rgbi_host (
   // Pixel link
   output logic o_pixel_clock,
   output logic o_vsync_n,
   output logic o_hsync_n,
   output logic o_pixel_valid,
   output logic [`RGBI_COLOR_W-1:0] o_red_bus,
   output logic [`RGBI_COLOR_W-1:0] o_green_bus,
   output logic [`RGBI_COLOR_W-1:0] o_blue_bus
);
   initial begin
      o_pixel_clock = 1'b0;
      #37;
      forever #80 o_pixel_clock = ~o_pixel_clock;
   end
   initial begin
      o_vsync_n = 1'b1;
      o_hsync_n = 1'b1;
      o_pixel_valid = 1'b0;
      {o_red_bus, o_green_bus, o_blue_bus} = 18'h0_0000;
   end
   task automatic drive(input logic vs, input logic hs, input logic v, input logic [17:0] d);
      @(posedge o_pixel_clock);
      #1;
      o_vsync_n = vs;
      o_hsync_n = hs;
      o_pixel_valid = v;
      {o_red_bus, o_green_bus, o_blue_bus} = d;
   endtask : drive
   task automatic idle(input int n);
      repeat (n) drive(1'b1, 1'b1, 1'b0, ~{o_red_bus, o_green_bus, o_blue_bus});
   endtask : idle
   task automatic vsync();
      repeat (2) drive(1'b0, 1'b1, 1'b0, ~{o_red_bus, o_green_bus, o_blue_bus});
      idle(4);
   endtask : vsync
   task automatic pixel(input logic [17:0] d, input logic v, input logic hs);
      drive(1'b1, hs, v, d);
   endtask : pixel
endmodule : rgbi_host

// *** test_rgbi_top.sv ***
/* Bench for rgbi_top: host model on the link, memory sink and pins here.
 * Assumes the checker and rgbi_host are compiled first. */
`timescale 1ns/1ps
`include "rgbi_defs.svh"
module test_rgbi_top;
   logic i_clk, i_srst, i_hard_reset_n, i_serial_select_n, i_rgb_mode, i_power_good;
   logic i_pixel_clock_in, i_vsync_n, i_hsync_n, i_pixel_valid, i_mem_wr_ready;
   logic o_mem_wr_valid, o_frame_start, o_display_blank, o_serial_select_active;
   logic o_panel_tag_bit0, o_panel_tag_bit1;
   logic [`RGBI_COLOR_W-1:0] i_red_bus, i_green_bus, i_blue_bus;
   logic [`RGBI_ADDR_W-1:0] o_mem_wr_addr;
   rgbi_pkg::rgbi_pixel_s o_mem_wr_pixel;
   logic [34:0] got[$];
   int miscompares, check_count, starts;
   rgbi_top u_rgbi_top (.i_clk, .i_srst, .i_hard_reset_n, .i_serial_select_n, .i_rgb_mode,
      .i_power_good, .i_pixel_clock_in, .i_vsync_n, .i_hsync_n, .i_pixel_valid, .i_red_bus,
      .i_green_bus, .i_blue_bus, .o_mem_wr_valid, .i_mem_wr_ready, .o_mem_wr_addr,
      .o_mem_wr_pixel, .o_frame_start, .o_display_blank, .o_serial_select_active,
      .o_panel_tag_bit0, .o_panel_tag_bit1);
   rgbi_host u_rgbi_host (.o_pixel_clock(i_pixel_clock_in), .o_vsync_n(i_vsync_n),
      .o_hsync_n(i_hsync_n), .o_pixel_valid(i_pixel_valid), .o_red_bus(i_red_bus),
      .o_green_bus(i_green_bus), .o_blue_bus(i_blue_bus));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // Memory sink
   always @(posedge i_clk) begin
      if (o_mem_wr_valid === 1'b1 && i_mem_wr_ready && !i_srst)
         got.push_back({o_mem_wr_addr, o_mem_wr_pixel});
      if (o_frame_start === 1'b1)
         starts++;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [34:0] g, input logic [34:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [17:0] px(input int i);
      return {6'(i * 5), 6'(i + 9), 6'(63 - i)};
   endfunction : px
   task automatic give_verdict();
      $display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   // Bounded wait for n words
   task automatic drain(input int n);
      for (int k = 0; k < 4000 && got.size() < n; k++) tick(1);
      if (got.size() < n) begin
         miscompares++;
         give_verdict();
      end
   endtask : drain
   // Skipped pixels leave no address gap
   task automatic t_frame();
      int sel[4] = '{0, 1, 3, 5};
      got.delete();
      starts = 0;
      u_rgbi_host.vsync();
      for (int i = 0; i < 6; i++) u_rgbi_host.pixel(px(i), i != 2, i != 4);
      u_rgbi_host.idle(2);
      drain(4);
      tick(20);
      chk(35'(starts), 35'd1);
      chk(35'(got.size()), 35'd4);
      for (int i = 0; i < 4; i++) chk(got[i], {17'(i), px(sel[i])});
      $display("t_frame done");
   endtask : t_frame
   // Fill until refused, then drain
   task automatic t_fifo();
      int n;
      got.delete();
      i_mem_wr_ready = 1'b0;
      u_rgbi_host.vsync();
      for (int i = 0; i < 14; i++) u_rgbi_host.pixel(px(i), 1'b1, 1'b1);
      u_rgbi_host.idle(2);
      tick(40);
      i_mem_wr_ready = 1'b1;
      drain(`RGBI_FIFO_DEPTH);
      tick(40);
      n = got.size();
      chk(35'(n >= `RGBI_FIFO_DEPTH && n < 14), 35'd1);
      for (int i = 0; i < n; i++) chk(got[i], {17'(i), px(i)});
      $display("t_fifo done");
   endtask : t_fifo
   task automatic t_rgb_off();
      i_rgb_mode = 1'b0;
      tick(20);
      got.delete();
      starts = 0;
      u_rgbi_host.vsync();
      for (int i = 0; i < 4; i++) u_rgbi_host.pixel(px(i), 1'b1, 1'b1);
      u_rgbi_host.idle(2);
      tick(40);
      i_rgb_mode = 1'b1;
      chk(35'(starts), 35'd0);
      chk(35'(got.size()), 35'd0);
      $display("t_rgb_off done");
   endtask : t_rgb_off
   task automatic t_hard();
      i_serial_select_n = 1'b0;
      i_hard_reset_n = 1'b0;
      tick(8);
      chk(35'(o_serial_select_active), 35'd0);
      i_hard_reset_n = 1'b1;
      tick(8);
      chk(35'(o_serial_select_active), 35'd1);
      chk(35'({o_panel_tag_bit1, o_panel_tag_bit0}), 35'({`RGBI_TAG_BIT1, `RGBI_TAG_BIT0}));
      i_serial_select_n = 1'b1;
      tick(20);
      chk(35'(o_serial_select_active), 35'd0);
      $display("t_hard done");
   endtask : t_hard
   task automatic t_power();
      i_power_good = 1'b0;
      tick(6);
      chk(35'(o_display_blank), 35'd1);
      i_power_good = 1'b1;
      tick(10);
      chk(35'(o_display_blank), 35'd1);
      i_srst = 1'b1;
      tick(12);
      i_srst = 1'b0;
      tick(20);
      chk(35'(o_display_blank), 35'd0);
      $display("t_power done");
   endtask : t_power
   initial begin
      i_srst = 1'b1;
      i_hard_reset_n = 1'b1;
      i_serial_select_n = 1'b1;
      i_rgb_mode = 1'b1;
      i_power_good = 1'b1;
      i_mem_wr_ready = 1'b1;
      tick(10);
      i_srst = 1'b0;
      tick(20);
      t_frame();
      tick(2);
      t_fifo();
      t_rgb_off();
      t_hard();
      t_power();
      give_verdict();
   end
endmodule : test_rgbi_top
